/* File: rtl/mailbox_pkg.sv */
// Purpose: shared constants for the dual processor mailbox port
// Assumes: byte-wide i/o cycles, one-cycle read and write strobes
// Notes:   address decode uses the full 8-bit i/o address
//
// Overview of operation
// - slave i/o 00h is store control, 20h inbound data, 30h outbound data
// - slave read at 50h returns the link status byte with both pending flags
// - access bit 0 puts the microcode store into copy mode
// - control bits 1-5 drive upper rom address lines a7-a10 and a12
// - slave inbound read returns the oldest master byte; down pending clears with the last one
// - slave outbound write stores byte for master and sets up pending flag
// - down pending reads 1 while a master byte is unread, else 0
// - up pending reads 1 while slave byte is unread by master, else 0
// - master write strobe at 80h resets the slave processor
// - master read at e0h returns slave byte and, without a same-cycle slave write, clears up pending flag
// - master write at f0h to a non-full fifo stores byte for slave and sets down pending flag
package mailbox_pkg;
    // ------------------------------------------------------------
    // slave i/o map
    // ------------------------------------------------------------
    localparam logic [7:0] SLV_STORE_CTL  = 8'h00;
    localparam logic [7:0] SLV_INBOUND    = 8'h20;
    localparam logic [7:0] SLV_OUTBOUND   = 8'h30;
    localparam logic [7:0] SLV_STATUS     = 8'h50;
    // ------------------------------------------------------------
    // master i/o map
    // ------------------------------------------------------------
    localparam logic [7:0] MST_SLAVE_RST  = 8'h80;
    localparam logic [7:0] MST_INBOUND    = 8'he0;
    localparam logic [7:0] MST_OUTBOUND   = 8'hf0;
    // ------------------------------------------------------------
    // store control fields
    // ------------------------------------------------------------
    localparam int         CTL_ACCESS_BIT = 0;
    localparam int         CTL_ROM_LSB    = 1;
    localparam int         ROM_ADDR_W     = 5;
    // ------------------------------------------------------------
    // status byte fields
    // ------------------------------------------------------------
    localparam int         ST_DOWN_BIT    = 0;
    localparam int         ST_UP_BIT      = 1;
    localparam int         ST_POWER_A_BIT = 2;
    localparam int         ST_POWER_B_BIT = 3;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int         DATA_W         = 8;
    localparam int         FIFO_DEPTH     = 16;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam logic [4:0] ROM_ADDR_RST   = 5'h00;
endpackage : mailbox_pkg

/* File: rtl/byte_stream_if.sv */
// Purpose: valid/ready byte stream between the port logic and its buffer
// Assumes: single clock domain
// Notes:   producer drives in_valid and in_data, consumer drives out_ready
`timescale 1ns/100ps
interface byte_stream_if #(parameter int WIDTH = 8);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;

    modport user (output in_valid, in_data, out_ready,
                  input  in_ready, out_valid, out_data);
    modport buffer (input  in_valid, in_data, out_ready,
                    output in_ready, out_valid, out_data);
endinterface : byte_stream_if

/* File: rtl/byte_fifo.sv */
// Purpose: synchronous fifo for the master-to-slave byte path
// Assumes: rst_n is already synchronised to clk_sys
// Notes:   in_ready and out_valid come from flip-flops
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // stream
    byte_stream_if.buffer   bus
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;
    logic             in_ready_q;
    logic             out_valid_q;

    assign push          = bus.in_valid && in_ready_q;
    assign pop           = bus.out_ready && out_valid_q;
    assign bus.in_ready  = in_ready_q;
    assign bus.out_valid = out_valid_q;
    assign bus.out_data  = mem_q[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= bus.in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            count_q     <= '0;
            in_ready_q  <= 1'b1;
            out_valid_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q     <= count_d;
            in_ready_q  <= (count_d != (AW+1)'(DEPTH));
            out_valid_q <= (count_d != '0);
        end
    end
endmodule : byte_fifo

/* File: rtl/mailbox_port.sv */
// Purpose: byte mailbox between master and slave processors, plus store control
// Assumes: i/o strobes are one clk_sys cycle wide and synchronous
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/100ps
module mailbox_port
    import mailbox_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // slave processor i/o
    input  wire logic [7:0]        slv_addr,
    input  wire logic [7:0]        slv_wdata,
    input  wire logic              slv_rd,
    input  wire logic              slv_wr,
    output logic      [7:0]        slv_rdata,
    // master processor i/o
    input  wire logic [7:0]        mst_addr,
    input  wire logic [7:0]        mst_wdata,
    input  wire logic              mst_rd,
    input  wire logic              mst_wr,
    output logic      [7:0]        mst_rdata,
    output logic                   mst_wr_ready,
    // system
    input  wire logic              power_fail_n,
    output logic                   slave_reset_strobe,
    output logic                   store_copy_mode,
    output logic [ROM_ADDR_W-1:0]  upper_rom_addr
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] port);
        hit = strobe && (addr == port);
    endfunction : hit

    logic slv_ctl_wr;
    logic slv_in_rd;
    logic slv_out_wr;
    logic slv_st_rd;
    logic mst_rst_wr;
    logic mst_in_rd;
    logic mst_out_wr;

    assign slv_ctl_wr = hit(slv_wr, slv_addr, SLV_STORE_CTL);
    assign slv_in_rd  = hit(slv_rd, slv_addr, SLV_INBOUND);
    assign slv_out_wr = hit(slv_wr, slv_addr, SLV_OUTBOUND);
    assign slv_st_rd  = hit(slv_rd, slv_addr, SLV_STATUS);
    assign mst_rst_wr = hit(mst_wr, mst_addr, MST_SLAVE_RST);
    assign mst_in_rd  = hit(mst_rd, mst_addr, MST_INBOUND);
    assign mst_out_wr = hit(mst_wr, mst_addr, MST_OUTBOUND);

    // ------------------------------------------------------------
    // master to slave path
    // ------------------------------------------------------------
    byte_stream_if #(.WIDTH(DATA_W)) down_if ();

    // a master write refused while full is dropped; mst_wr_ready falls one cycle after the fifo fills
    assign down_if.in_valid  = mst_out_wr;
    assign down_if.in_data   = mst_wdata;
    assign down_if.out_ready = slv_in_rd;

    byte_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_down_fifo (
        .clk_sys (clk_sys),
        .rst_n   (rst_n_q),
        .bus     (down_if.buffer)
    );

    logic down_pending;
    assign down_pending = down_if.out_valid;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mst_wr_ready <= 1'b0;
        end else begin
            mst_wr_ready <= down_if.in_ready;
        end
    end

    // ------------------------------------------------------------
    // slave to master path
    // ------------------------------------------------------------
    logic [7:0] up_byte_q;
    logic       up_pending_q;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            up_byte_q <= BYTE_ZERO;
        end else if (slv_out_wr) begin
            up_byte_q <= slv_wdata;
        end
    end

    // set wins over a same-cycle master read
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            up_pending_q <= 1'b0;
        end else if (slv_out_wr) begin
            up_pending_q <= 1'b1;
        end else if (mst_in_rd) begin
            up_pending_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // store control
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            store_copy_mode <= 1'b0;
            upper_rom_addr  <= ROM_ADDR_RST;
        end else if (slv_ctl_wr) begin
            store_copy_mode <= slv_wdata[CTL_ACCESS_BIT];
            upper_rom_addr  <= slv_wdata[CTL_ROM_LSB +: ROM_ADDR_W];
        end
    end

    // ------------------------------------------------------------
    // slave reset strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            slave_reset_strobe <= 1'b0;
        end else begin
            slave_reset_strobe <= mst_rst_wr;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] status_byte;

    always_comb begin
        status_byte                 = BYTE_ZERO;
        status_byte[ST_DOWN_BIT]    = down_pending;
        status_byte[ST_UP_BIT]      = up_pending_q;
        status_byte[ST_POWER_A_BIT] = power_fail_n;
        status_byte[ST_POWER_B_BIT] = power_fail_n;
    end

    // unused slave addresses read as zero and change nothing
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            slv_rdata <= BYTE_ZERO;
        end else if (slv_in_rd) begin
            slv_rdata <= down_if.out_data;
        end else if (slv_st_rd) begin
            slv_rdata <= status_byte;
        end else if (slv_rd) begin
            slv_rdata <= BYTE_ZERO;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mst_rdata <= BYTE_ZERO;
        end else if (mst_in_rd) begin
            mst_rdata <= up_byte_q;
        end else if (mst_rd) begin
            mst_rdata <= BYTE_ZERO;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n_q);

    // bytes accepted from the master and not yet taken by the slave
    logic                        push_seen;
    logic                        pop_seen;
    logic [$clog2(FIFO_DEPTH):0] held_q;

    assign push_seen = mst_out_wr && down_if.in_ready;
    assign pop_seen  = slv_in_rd && down_pending;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            held_q <= '0;
        end else if (push_seen && !pop_seen) begin
            held_q <= held_q + 1'b1;
        end else if (pop_seen && !push_seen) begin
            held_q <= held_q - 1'b1;
        end
    end

    sequence s_master_push;
        mst_out_wr && down_if.in_ready;
    endsequence

    sequence s_slave_takes_last;
        slv_in_rd && held_q == 1'b1 && !mst_out_wr;
    endsequence

    property p_down_set;
        s_master_push |=> down_pending ##1 (down_pending || $past(slv_in_rd));
    endproperty
    a_down_set: assert property (p_down_set) else $error("down flag not set by master write");

    property p_inbound_data;
        slv_in_rd && down_pending |=> slv_rdata == $past(down_if.out_data);
    endproperty
    a_inbound_data: assert property (p_inbound_data) else $error("inbound byte wrong");

    property p_up_set;
        slv_out_wr |=> up_pending_q && up_byte_q == $past(slv_wdata);
    endproperty
    a_up_set: assert property (p_up_set) else $error("up flag or byte not stored");

    property p_up_clear;
        mst_in_rd && !slv_out_wr |=> !up_pending_q && mst_rdata == $past(up_byte_q);
    endproperty
    a_up_clear: assert property (p_up_clear) else $error("master read did not clear up flag");

    property p_up_hold;
        up_pending_q && !mst_in_rd |=> up_pending_q;
    endproperty
    a_up_hold: assert property (p_up_hold) else $error("up flag lost without master read");

    property p_status;
        slv_st_rd |=> slv_rdata[ST_UP_BIT] == $past(up_pending_q)
            && slv_rdata[ST_DOWN_BIT] == $past(down_pending)
            && slv_rdata[ST_POWER_A_BIT] == $past(power_fail_n)
            && slv_rdata[ST_POWER_B_BIT] == $past(power_fail_n)
            && slv_rdata[DATA_W-1:ST_POWER_B_BIT+1] == '0;
    endproperty
    a_status: assert property (p_status) else $error("status byte wrong");

    property p_store_ctl;
        slv_ctl_wr |=> store_copy_mode == $past(slv_wdata[CTL_ACCESS_BIT])
            && upper_rom_addr == $past(slv_wdata[CTL_ROM_LSB +: ROM_ADDR_W]);
    endproperty
    a_store_ctl: assert property (p_store_ctl) else $error("store control not latched");

    property p_slave_reset;
        mst_rst_wr |=> slave_reset_strobe;
    endproperty
    a_slave_reset: assert property (p_slave_reset) else $error("slave reset strobe missing");

    property p_unused_quiet;
        slv_wr && !slv_ctl_wr && !slv_out_wr
            |=> $stable(store_copy_mode) && $stable(upper_rom_addr) && $stable(up_byte_q);
    endproperty
    a_unused_quiet: assert property (p_unused_quiet) else $error("unused address had side effect");

    property p_down_level;
        down_pending == (held_q != '0);
    endproperty
    a_down_level: assert property (p_down_level) else $error("down flag does not match bytes held");

    property p_down_clear;
        s_slave_takes_last |=> !down_pending;
    endproperty
    a_down_clear: assert property (p_down_clear) else $error("down flag not cleared by last read");

    property p_full_warn;
        held_q == FIFO_DEPTH |=> !mst_wr_ready;
    endproperty
    a_full_warn: assert property (p_full_warn) else $error("write ready high while full");

    property p_up_idle;
        !up_pending_q && !slv_out_wr |=> !up_pending_q;
    endproperty
    a_up_idle: assert property (p_up_idle) else $error("up flag set without slave write");

    property p_up_byte_hold;
        !slv_out_wr |=> $stable(up_byte_q);
    endproperty
    a_up_byte_hold: assert property (p_up_byte_hold) else $error("up byte changed without slave write");

    property p_store_hold;
        !slv_ctl_wr |=> $stable(store_copy_mode) && $stable(upper_rom_addr);
    endproperty
    a_store_hold: assert property (p_store_hold) else $error("store control changed without write");

    property p_strobe_pulse;
        slave_reset_strobe && !mst_rst_wr |=> !slave_reset_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("slave reset strobe too long");

    property p_unused_read;
        slv_rd && !slv_in_rd && !slv_st_rd |=> slv_rdata == BYTE_ZERO;
    endproperty
    a_unused_read: assert property (p_unused_read) else $error("unused address read not zero");
endmodule : mailbox_port

/* File: tb/master_model.sv */
// Purpose: master processor model on the master i/o bus of the mailbox port
// Assumes: one-cycle strobes launched 2 ns after the rising edge of clk_sys
// Notes:   address and data lines show the inverse of the last value while idle
`timescale 1ns/100ps
module master_model #(
    parameter logic [7:0] CODE_OK_A = 8'h5a,
    parameter logic [7:0] CODE_OK_B = 8'ha5
) (
    // clock
    input  wire logic       clk_sys,
    // master i/o
    output logic      [7:0] mst_addr,
    output logic      [7:0] mst_wdata,
    output logic            mst_rd,
    output logic            mst_wr,
    input  wire logic [7:0] mst_rdata,
    input  wire logic       mst_wr_ready,
    // verdicts
    output logic            write_fail,
    output logic            checkout_fail
);
    initial begin
        mst_addr      = 8'h00;
        mst_wdata     = 8'h00;
        mst_rd        = 1'b0;
        mst_wr        = 1'b0;
        write_fail    = 1'b0;
        checkout_fail = 1'b0;
    end

    task automatic bus_cycle(input logic [7:0] a, input logic [7:0] d, input logic wr, output logic [7:0] q);
        @(posedge clk_sys);
        #2;
        mst_addr  = a;
        mst_wdata = d;
        mst_rd    = ~wr;
        mst_wr    = wr;
        @(posedge clk_sys);
        #2;
        mst_rd    = 1'b0;
        mst_wr    = 1'b0;
        mst_addr  = ~a;
        mst_wdata = ~d;
        q         = mst_rdata;
    endtask : bus_cycle

    task automatic reset_slave();
        logic [7:0] q;
        bus_cycle(8'h80, 8'h00, 1'b1, q);
    endtask : reset_slave

    // a byte the slave never takes leaves the port full: give up and flag it
    task automatic send(input logic [7:0] d);
        logic [7:0] q;
        @(posedge clk_sys);
        #1;
        if (mst_wr_ready !== 1'b1) begin
            write_fail = 1'b1;
        end else begin
            bus_cycle(8'hf0, d, 1'b1, q);
        end
    endtask : send

    task automatic take_status(output logic [7:0] q);
        bus_cycle(8'he0, 8'h00, 1'b0, q);
        if (q !== CODE_OK_A && q !== CODE_OK_B) begin
            checkout_fail = 1'b1;
        end
    endtask : take_status
endmodule : master_model

/* File: tb/tb.sv */
// Purpose: self-checking bench for the mailbox port, bench plays the slave
// Assumes: inputs change 2 ns after the rising edge, read data one cycle later
// Notes:   unused reads are expected as 00, the value the design chose
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb
    import mailbox_pkg::*;
;
    logic                  clk_sys;
    logic                  resetn;
    logic [7:0]            slv_addr;
    logic [7:0]            slv_wdata;
    logic                  slv_rd;
    logic                  slv_wr;
    logic [7:0]            slv_rdata;
    logic [7:0]            mst_addr;
    logic [7:0]            mst_wdata;
    logic                  mst_rd;
    logic                  mst_wr;
    logic [7:0]            mst_rdata;
    logic                  mst_wr_ready;
    logic                  power_fail_n;
    logic                  slave_reset_strobe;
    logic                  store_copy_mode;
    logic [ROM_ADDR_W-1:0] upper_rom_addr;
    logic                  write_fail;
    logic                  checkout_fail;
    int                    n_fail;
    int                    compares;

    mailbox_port i_mailbox_port (
        .clk_sys(clk_sys), .resetn(resetn), .slv_addr(slv_addr), .slv_wdata(slv_wdata), .slv_rd(slv_rd),
        .slv_wr(slv_wr), .slv_rdata(slv_rdata), .mst_addr(mst_addr), .mst_wdata(mst_wdata), .mst_rd(mst_rd),
        .mst_wr(mst_wr), .mst_rdata(mst_rdata), .mst_wr_ready(mst_wr_ready), .power_fail_n(power_fail_n),
        .slave_reset_strobe(slave_reset_strobe), .store_copy_mode(store_copy_mode), .upper_rom_addr(upper_rom_addr));

    master_model i_master_model (
        .clk_sys(clk_sys), .mst_addr(mst_addr), .mst_wdata(mst_wdata), .mst_rd(mst_rd), .mst_wr(mst_wr),
        .mst_rdata(mst_rdata), .mst_wr_ready(mst_wr_ready), .write_fail(write_fail),
        .checkout_fail(checkout_fail));

    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    task automatic slv_cycle(input logic [7:0] a, input logic [7:0] d, input logic wr, output logic [7:0] q);
        @(posedge clk_sys);
        #2;
        slv_addr  = a;
        slv_wdata = d;
        slv_rd    = ~wr;
        slv_wr    = wr;
        @(posedge clk_sys);
        #2;
        slv_rd    = 1'b0;
        slv_wr    = 1'b0;
        slv_addr  = ~a;
        slv_wdata = ~d;
        q         = slv_rdata;
    endtask : slv_cycle

    task automatic chk_status(input logic [7:0] exp);
        logic [7:0] q;
        slv_cycle(SLV_STATUS, 8'h00, 1'b0, q);
        `CHK(q, exp)
    endtask : chk_status

    task automatic t_reset();
        chk_status(8'h0c);
        `CHK(store_copy_mode, 1'b0)
        `CHK(upper_rom_addr, 5'h00)
        `CHK(mst_wr_ready, 1'b1)
    endtask : t_reset

    task automatic t_slave_reset();
        i_master_model.reset_slave();
        `CHK(slave_reset_strobe, 1'b1)
        @(posedge clk_sys);
        #2;
        `CHK(slave_reset_strobe, 1'b0)
    endtask : t_slave_reset

    task automatic t_store_ctl();
        logic [7:0] v [4] = '{8'h01, 8'h3e, 8'h2b, 8'h00};
        logic [7:0] u [5] = '{8'h40, 8'h60, 8'h70, 8'h20, 8'h50};
        logic [7:0] q;
        for (int i = 0; i < 4; i++) begin
            slv_cycle(SLV_STORE_CTL, v[i], 1'b1, q);
            `CHK(store_copy_mode, v[i][0])
            `CHK(upper_rom_addr, v[i][5:1])
        end
        slv_cycle(SLV_STORE_CTL, 8'h15, 1'b1, q);
        for (int i = 0; i < 5; i++) begin
            slv_cycle(u[i], 8'hff, 1'b1, q);
        end
        slv_cycle(8'h40, 8'h00, 1'b0, q);
        `CHK(q, 8'h00)
        `CHK(store_copy_mode, 1'b1)
        `CHK(upper_rom_addr, 5'h0a)
        chk_status(8'h0c);
    endtask : t_store_ctl

    task automatic t_down();
        logic [7:0] q;
        for (int i = 1; i <= 3; i++) begin
            i_master_model.send(8'(i * 17));
        end
        chk_status(8'h0d);
        for (int i = 1; i <= 3; i++) begin
            slv_cycle(SLV_INBOUND, 8'h00, 1'b0, q);
            `CHK(q, 8'(i * 17))
        end
        chk_status(8'h0c);
    endtask : t_down

    task automatic t_fill();
        logic [7:0] q;
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            i_master_model.send(8'(8'h40 + i));
        end
        @(posedge clk_sys);
        #2;
        `CHK(mst_wr_ready, 1'b0)
        `CHK(write_fail, 1'b0)
        i_master_model.send(8'hee);
        `CHK(write_fail, 1'b1)
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            slv_cycle(SLV_INBOUND, 8'h00, 1'b0, q);
            `CHK(q, 8'(8'h40 + i))
        end
        chk_status(8'h0c);
        `CHK(mst_wr_ready, 1'b1)
    endtask : t_fill

    task automatic t_up();
        logic [7:0] q;
        slv_cycle(SLV_OUTBOUND, 8'h5a, 1'b1, q);
        chk_status(8'h0e);
        i_master_model.take_status(q);
        `CHK(q, 8'h5a)
        `CHK(checkout_fail, 1'b0)
        chk_status(8'h0c);
        slv_cycle(SLV_OUTBOUND, 8'h77, 1'b1, q);
        i_master_model.take_status(q);
        `CHK(q, 8'h77)
        `CHK(checkout_fail, 1'b1)
    endtask : t_up

    task automatic t_power_fail();
        @(posedge clk_sys);
        #2;
        power_fail_n = 1'b0;
        chk_status(8'h00);
        power_fail_n = 1'b1;
        chk_status(8'h0c);
    endtask : t_power_fail

    // reset in mid-run with bytes pending both ways and copy mode set
    task automatic t_mid_reset();
        logic [7:0] q;
        i_master_model.send(8'h99);
        slv_cycle(SLV_OUTBOUND, 8'h31, 1'b1, q);
        slv_cycle(SLV_STORE_CTL, 8'h3f, 1'b1, q);
        @(posedge clk_sys);
        #2;
        resetn = 1'b0;
        @(posedge clk_sys);
        #2;
        `CHK(store_copy_mode, 1'b0)
        `CHK(upper_rom_addr, 5'h00)
        `CHK(mst_wr_ready, 1'b0)
        resetn = 1'b1;
        repeat (3) @(posedge clk_sys);
        chk_status(8'h0c);
        `CHK(mst_wr_ready, 1'b1)
    endtask : t_mid_reset

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        summarize();
    end

    initial begin
        n_fail       = 0;
        compares     = 0;
        resetn       = 1'b0;
        power_fail_n = 1'b1;
        slv_addr     = 8'h00;
        slv_wdata    = 8'h00;
        slv_rd       = 1'b0;
        slv_wr       = 1'b0;
        repeat (4) @(posedge clk_sys);
        #2;
        resetn = 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_slave_reset();
        t_store_ctl();
        t_down();
        t_fill();
        t_up();
        t_power_fail();
        t_mid_reset();
        summarize();
    end
endmodule : tb
